// ---- rtl/tmr_cfg_pkg.sv ----
// constants for the timer clock select and mode configuration block
// assumes a single system clock phi and an 8-bit register port
package tmr_cfg_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_CH = 6;
  localparam int NUM_SEL_CH = 4;
  localparam int NUM_EXT = 4;
  localparam int NUM_CD_CH = 2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PRE_W = 12;
  localparam int NUM_TAP = 7;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [3:0] MODE_BASE = 4'h0;
  localparam logic [3:0] MODE_LAST = 4'h5;
  localparam logic [3:0] CSEL_BASE = 4'h8;
  localparam logic [3:0] CSEL_LAST = 4'hb;

  // ****************************************************************
  // mode register fields and reset values
  // ****************************************************************
  localparam int BUF_B_BIT = 5;
  localparam int BUF_A_BIT = 4;
  localparam int OP_SEL_BIT3 = 3;
  localparam int OP_SEL_BIT2 = 2;
  localparam logic [1:0] MODE_RSV_HI = 2'h3;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [5:0] MODE_WMASK_CD = 6'h3f;
  localparam logic [5:0] MODE_WMASK_NOCD = 6'h0f;
  localparam logic [NUM_CH-1:0] HAS_CD = 6'h09;
  localparam logic [2:0] CSEL_RESET = 3'h0;
  localparam logic [2:0] CSEL_FIELD_ZERO = 3'h0;

  // ****************************************************************
  // operating mode codes
  // ****************************************************************
  localparam logic [3:0] OP_NORMAL = 4'h0;
  localparam logic [3:0] OP_PWM1 = 4'h2;
  localparam logic [3:0] OP_PWM2 = 4'h3;
  localparam logic [1:0] OP_PHASE_HI = 2'h1;

  // ****************************************************************
  // clock select codes and prescaler taps
  // ****************************************************************
  localparam logic [2:0] CS_DIV1 = 3'h0;
  localparam logic [2:0] CS_TOP = 3'h7;
  localparam logic [3:0] CH3_MODE_ADDR = 4'h3;
  // tap k ticks when the low TAP_W[k] prescaler bits are all ones
  // taps: phi/1, /4, /16, /64, /256, /1024, /4096
  localparam int TAP_W [NUM_TAP] = '{0, 2, 4, 6, 8, 10, 12};
  localparam int TAP_DIV1 = 0;
  localparam int TAP_DIV4 = 1;
  localparam int TAP_DIV16 = 2;
  localparam int TAP_DIV64 = 3;
  localparam int TAP_DIV256 = 4;
  localparam int TAP_DIV1024 = 5;
  localparam int TAP_DIV4096 = 6;

endpackage

// ---- rtl/ext_edge_sync.sv ----
// two-flop synchroniser with rising edge detection for one count pin
// assumes the pin is asynchronous to mclk_i
`timescale 1ns/1ps
module ext_edge_sync
(
  // clock and control
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // pin and edge
  input wire logic pin_i,
  output logic rise_o
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // ****************************************************************
  // synchroniser
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else if (ce_i)
    begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // one pulse per rising edge of the synchronised level
  assign rise_o = sync_r & ~last_r; // [RQ15]

endmodule

// ---- rtl/timer_clock_select_mode_cfg.sv ----
// clock select and mode registers for a six-channel pulse timer unit
// assumes a register port master on mclk_i and async count pins
// Operation
// RQ1: ch2 select: phi/1,/4,/16,/64, pins a,b,c, then phi/1024.
// RQ2: ch3 select: phi/1../64, pin a, then phi/1024, /256, /4096.
// RQ3: ch4 select: phi/1../64, pins a, c, phi/1024, ch5 wrap.
// RQ4: ch5 select: phi/1../64, pins a, c, phi/256, pin d.
// RQ5: channels 2, 4, 5 ignore clock select in phase counting modes.
// RQ6: each of six channels owns an independent 8-bit mode register.
// RQ7: software changes a mode register only while that counter halts.
// RQ8: mode bits 7 and 6 read one; writes to them do nothing.
// RQ9: bit 5 pairs registers b and d; d then raises no events.
// RQ10: bit 4 pairs registers a and c; c then raises no events.
// RQ11: channels 1, 2, 4, 5 read buffer bits as zero, ignore writes.
// RQ12: software writes zero to mode bit 3; mode field resets zero.
// RQ13: mode 0 normal, 2 pwm1, 3 pwm2, 4 to 7 phase 1 to 4.
// RQ14: software never selects phase counting on channels 0 and 3.
// RQ15: count pins synchronised; one count per detected rising edge.
`timescale 1ns/1ps
module timer_clock_select_mode_cfg
  import tmr_cfg_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // count sources
  input wire logic ext_count_in_a_i,
  input wire logic ext_count_in_b_i,
  input wire logic ext_count_in_c_i,
  input wire logic ext_count_in_d_i,
  input wire logic ch5_counter_wrap_i,
  // count advance strobes for channels 2 to 5
  output logic [NUM_SEL_CH-1:0] count_tick_o,
  // decoded mode per channel
  output logic [NUM_CH-1:0] buffer_pair_a_en_o,
  output logic [NUM_CH-1:0] buffer_pair_b_en_o,
  output logic [NUM_CH-1:0] op_normal_o,
  output logic [NUM_CH-1:0] op_pwm1_o,
  output logic [NUM_CH-1:0] op_pwm2_o,
  output logic [NUM_CH-1:0] op_phase_o,
  output logic [2*NUM_CH-1:0] op_phase_sel_o,
  // register c and d events of channels 0 and 3
  input wire logic [NUM_CD_CH-1:0] gr_c_event_i,
  input wire logic [NUM_CD_CH-1:0] gr_d_event_i,
  output logic [NUM_CD_CH-1:0] gr_c_event_o,
  output logic [NUM_CD_CH-1:0] gr_d_event_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic rst_s1_r;
  logic rst_n;
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [NUM_TAP-1:0] div_tick;
  logic [NUM_EXT-1:0] ext_pin;
  logic [NUM_EXT-1:0] ext_rise;
  logic [5:0] mode_r [NUM_CH];
  logic [2:0] csel_r [NUM_SEL_CH];
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rd_val;
  logic [NUM_SEL_CH-1:0] count_tick_r;
  logic [NUM_SEL_CH-1:0] tick_nxt;
  logic [7:0] src2;
  logic [7:0] src3;
  logic [7:0] src4;
  logic [7:0] src5;
  logic mode_hit;
  logic csel_hit;
  logic [2:0] mode_idx;
  logic [1:0] csel_idx;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // reset release
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ****************************************************************
  // prescaler
  // ****************************************************************
  assign pre_nxt = pre_r + 1'b1;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      pre_r <= '0;
    else if (ce_i)
      pre_r <= pre_nxt;
  end

  for (genvar k = 0; k < NUM_TAP; k++)
  begin : g_tap
    if (TAP_W[k] == 0)
    begin : g_div1
      assign div_tick[k] = 1'b1;
    end
    else
    begin : g_divn
      assign div_tick[k] = &pre_r[TAP_W[k]-1:0];
    end
  end

  // ****************************************************************
  // external count pins
  // ****************************************************************
  assign ext_pin = {ext_count_in_d_i, ext_count_in_c_i,
                    ext_count_in_b_i, ext_count_in_a_i};

  for (genvar p = 0; p < NUM_EXT; p++)
  begin : g_ext
    ext_edge_sync u_sync
    (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .pin_i(ext_pin[p]),
      .rise_o(ext_rise[p])
    );
  end

  // ****************************************************************
  // register decode
  // ****************************************************************
  assign mode_hit = (addr_i >= MODE_BASE) && (addr_i <= MODE_LAST);
  assign csel_hit = (addr_i >= CSEL_BASE) && (addr_i <= CSEL_LAST);
  assign mode_idx = 3'(addr_i - MODE_BASE);
  assign csel_idx = 2'(addr_i - CSEL_BASE);

  // ****************************************************************
  // mode registers
  // ****************************************************************
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_mode
    logic mode_we;
    logic [5:0] wmask;
    assign mode_we = wr_i && (addr_i == (MODE_BASE + 4'(c)));
    // buffer bits exist only where registers c and d exist
    assign wmask = HAS_CD[c] ? MODE_WMASK_CD : MODE_WMASK_NOCD; // [RQ11]

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
      if (!rst_n)
        mode_r[c] <= MODE_RESET; // [RQ12]
      else if (ce_i && mode_we)
        mode_r[c] <= wdata_i[5:0] & wmask; // [RQ6]
    end

    assign buffer_pair_a_en_o[c] = mode_r[c][BUF_A_BIT]; // [RQ10]
    assign buffer_pair_b_en_o[c] = mode_r[c][BUF_B_BIT]; // [RQ9]
    assign op_normal_o[c] = mode_r[c][3:0] == OP_NORMAL; // [RQ13]
    assign op_pwm1_o[c] = mode_r[c][3:0] == OP_PWM1; // [RQ13]
    assign op_pwm2_o[c] = mode_r[c][3:0] == OP_PWM2; // [RQ13]
    assign op_phase_o[c] = mode_r[c][3:2] == OP_PHASE_HI; // [RQ13]
    assign op_phase_sel_o[2*c +: 2] = mode_r[c][1:0]; // [RQ13]
  end

  // ****************************************************************
  // clock select registers, channels 2 to 5
  // ****************************************************************
  for (genvar s = 0; s < NUM_SEL_CH; s++)
  begin : g_csel
    logic csel_we;
    assign csel_we = wr_i && (addr_i == (CSEL_BASE + 4'(s)));

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
      if (!rst_n)
        csel_r[s] <= CSEL_RESET;
      else if (ce_i && csel_we)
        csel_r[s] <= wdata_i[2:0];
    end
  end

  // ****************************************************************
  // count source selection
  // ****************************************************************
  assign src2 = {div_tick[TAP_DIV1024], ext_rise[2], ext_rise[1],
                 ext_rise[0], div_tick[TAP_DIV64], div_tick[TAP_DIV16],
                 div_tick[TAP_DIV4], div_tick[TAP_DIV1]}; // [RQ1]
  assign src3 = {div_tick[TAP_DIV4096], div_tick[TAP_DIV256],
                 div_tick[TAP_DIV1024], ext_rise[0],
                 div_tick[TAP_DIV64], div_tick[TAP_DIV16],
                 div_tick[TAP_DIV4], div_tick[TAP_DIV1]}; // [RQ2]
  assign src4 = {ch5_counter_wrap_i, div_tick[TAP_DIV1024], ext_rise[2],
                 ext_rise[0], div_tick[TAP_DIV64], div_tick[TAP_DIV16],
                 div_tick[TAP_DIV4], div_tick[TAP_DIV1]}; // [RQ3]
  assign src5 = {ext_rise[3], div_tick[TAP_DIV256], ext_rise[2],
                 ext_rise[0], div_tick[TAP_DIV64], div_tick[TAP_DIV16],
                 div_tick[TAP_DIV4], div_tick[TAP_DIV1]}; // [RQ4]

  // phase counting channels take their count from the phase logic
  assign tick_nxt[0] = src2[csel_r[0]] & ~op_phase_o[2]; // [RQ5]
  assign tick_nxt[1] = src3[csel_r[1]];
  assign tick_nxt[2] = src4[csel_r[2]] & ~op_phase_o[4]; // [RQ5]
  assign tick_nxt[3] = src5[csel_r[3]] & ~op_phase_o[5]; // [RQ5]

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      count_tick_r <= '0;
    else if (ce_i)
      count_tick_r <= tick_nxt; // [RQ15]
  end

  assign count_tick_o = count_tick_r;

  // ****************************************************************
  // buffer pairing event suppression, channels 0 and 3
  // ****************************************************************
  assign gr_c_event_o[0] = gr_c_event_i[0] & ~mode_r[0][BUF_A_BIT]; // [RQ10]
  assign gr_c_event_o[1] = gr_c_event_i[1] & ~mode_r[3][BUF_A_BIT]; // [RQ10]
  assign gr_d_event_o[0] = gr_d_event_i[0] & ~mode_r[0][BUF_B_BIT]; // [RQ9]
  assign gr_d_event_o[1] = gr_d_event_i[1] & ~mode_r[3][BUF_B_BIT]; // [RQ9]

  // ****************************************************************
  // read port
  // ****************************************************************
  assign rd_val = mode_hit ? {MODE_RSV_HI, mode_r[mode_idx]} : // [RQ8]
                  csel_hit ? {5'h00, csel_r[csel_idx]} : 8'h00;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= '0;
    else if (ce_i && rd_i)
      rdata_r <= rd_val;
  end

  assign rdata_o = rdata_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  ch2_div1_a: assert property ( // [RQ1]
    ce_i && csel_r[0] == CS_DIV1 && !op_phase_o[2] |=> count_tick_o[0])
    else $error("ch2 phi/1 select did not tick");

  ch3_div4096_a: assert property ( // [RQ2]
    ce_i && csel_r[1] == CS_TOP
    |=> count_tick_o[1] == $past(div_tick[TAP_DIV4096]))
    else $error("ch3 phi/4096 select mismatch");

  ch4_cascade_a: assert property ( // [RQ3]
    ce_i && csel_r[2] == CS_TOP && !op_phase_o[4]
    |=> count_tick_o[2] == $past(ch5_counter_wrap_i))
    else $error("ch4 cascade tick mismatch");

  ch5_pin_d_a: assert property ( // [RQ4]
    ce_i && csel_r[3] == CS_TOP && !op_phase_o[5]
    |=> count_tick_o[3] == $past(ext_rise[3]))
    else $error("ch5 pin d tick mismatch");

  phase_ignore_a: assert property ( // [RQ5]
    ce_i && (op_phase_o[2] || op_phase_o[4])
    |=> !(count_tick_o[0] && $past(op_phase_o[2]))
        && !(count_tick_o[2] && $past(op_phase_o[4])))
    else $error("phase counting channel ticked from select");

  mode_indep_a: assert property ( // [RQ6]
    ce_i && wr_i && addr_i == MODE_BASE + 4'h1 |=> $stable(mode_r[0]))
    else $error("write to ch1 mode disturbed ch0");

  rsv_high_a: assert property ( // [RQ8]
    ce_i && rd_i && mode_hit |=> rdata_o[7:6] == MODE_RSV_HI)
    else $error("mode bits 7:6 not read as one");

  buf_b_gate_a: assert property ( // [RQ9]
    buffer_pair_b_en_o[3] |-> !gr_d_event_o[1])
    else $error("ch3 d event while paired");

  buf_a_pass_a: assert property ( // [RQ10]
    !buffer_pair_a_en_o[0] |-> gr_c_event_o[0] == gr_c_event_i[0])
    else $error("ch0 c event lost while unpaired");

  rsv_buf_a: assert property ( // [RQ11]
    ce_i && wr_i && addr_i == MODE_BASE + 4'h2
    |=> mode_r[2][BUF_B_BIT:BUF_A_BIT] == 2'h0)
    else $error("ch2 buffer bits stored");

  op_decode_a: assert property ( // [RQ13]
    ce_i && wr_i && addr_i == MODE_BASE && wdata_i[3:0] == OP_PWM2
    |=> op_pwm2_o[0] && !op_pwm1_o[0] && !op_normal_o[0])
    else $error("pwm mode 2 decode wrong");

  ext_single_a: assert property ( // [RQ15]
    ce_i && ext_rise[0] ##1 ce_i |-> !ext_rise[0])
    else $error("pin a edge counted twice");

  ch2_pin_b_a: assert property ( // [RQ1]
    ce_i && csel_r[0] == 3'h5 && !op_phase_o[2]
    |=> count_tick_o[0] == $past(ext_rise[1]))
    else $error("ch2 pin b tick mismatch");

  ch3_pin_a_a: assert property ( // [RQ2]
    ce_i && csel_r[1] == 3'h4
    |=> count_tick_o[1] == $past(ext_rise[0]))
    else $error("ch3 pin a tick mismatch");

  ch4_pin_c_a: assert property ( // [RQ3]
    ce_i && csel_r[2] == 3'h5 && !op_phase_o[4]
    |=> count_tick_o[2] == $past(ext_rise[2]))
    else $error("ch4 pin c tick mismatch");

  ch5_div256_a: assert property ( // [RQ4]
    ce_i && csel_r[3] == 3'h6 && !op_phase_o[5]
    |=> count_tick_o[3] == $past(div_tick[TAP_DIV256]))
    else $error("ch5 phi/256 tick mismatch");

  ch5_phase_a: assert property ( // [RQ5]
    ce_i && op_phase_o[5] |=> !count_tick_o[3])
    else $error("ch5 ticked from select in phase mode");

  buf_d0_gate_a: assert property ( // [RQ9]
    buffer_pair_b_en_o[0] |-> !gr_d_event_o[0])
    else $error("ch0 d event while paired");

  buf_c3_gate_a: assert property ( // [RQ10]
    buffer_pair_a_en_o[3] |-> !gr_c_event_o[1])
    else $error("ch3 c event while paired");

  ch2_pin_cov: cover property (
    ce_i && csel_r[0] == 3'h4 && ext_rise[0] ##1 count_tick_o[0]);
  ch4_wrap_cov: cover property (
    ce_i && csel_r[2] == CS_TOP && ch5_counter_wrap_i ##1 count_tick_o[2]);
  phase_cov: cover property (ce_i && op_phase_o[5]);
  pair_cov: cover property (
    ce_i && wr_i && addr_i == CH3_MODE_ADDR && wdata_i[BUF_A_BIT]);

endmodule

// ---- verif/test_timer_clock_select_mode_cfg.sv ----
// self-checking bench for the timer clock select and mode block
// assumes the design package, one 20 MHz clock and no counter datapath
`timescale 1ns/1ps
module test_timer_clock_select_mode_cfg;
  import tmr_cfg_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [4:0] src_r = '0;
  logic [NUM_CD_CH-1:0] c_ev_r = '0;
  logic [NUM_CD_CH-1:0] d_ev_r = '0;
  logic [DATA_W-1:0] rdata_o;
  logic [NUM_SEL_CH-1:0] count_tick_o;
  logic [NUM_CH-1:0] buf_a_o;
  logic [NUM_CH-1:0] buf_b_o;
  logic [NUM_CH-1:0] nrm_o;
  logic [NUM_CH-1:0] pw1_o;
  logic [NUM_CH-1:0] pw2_o;
  logic [NUM_CH-1:0] phs_o;
  logic [2*NUM_CH-1:0] psel_o;
  logic [NUM_CD_CH-1:0] c_o;
  logic [NUM_CD_CH-1:0] d_o;
  int err_total = 0;
  int n_compared = 0;
  int tick_cnt [NUM_SEL_CH] = '{default: 0};
  int ps_ch [13] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 3, 3};
  int ps_cs [13] = '{0, 1, 2, 3, 7, 2, 5, 6, 7, 1, 6, 3, 6};
  int ps_dv [13] = '{1, 4, 16, 64, 1024, 16, 1024, 256, 4096, 4, 1024,
    64, 256};
  int ex_ch [10] = '{0, 0, 0, 1, 2, 2, 2, 3, 3, 3};
  int ex_cs [10] = '{4, 5, 6, 4, 4, 5, 7, 4, 5, 7};
  int ex_sr [10] = '{0, 1, 2, 0, 0, 2, 4, 0, 2, 3};

  always #25 mclk_i = ~mclk_i;

  // counts ticks seen per channel, an unknown counts as a tick
  always @(posedge mclk_i)
    for (int k = 0; k < NUM_SEL_CH; k++)
      tick_cnt[k] <= tick_cnt[k] + int'(count_tick_o[k] !== 1'b0);

  timer_clock_select_mode_cfg DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o),
    .ext_count_in_a_i(src_r[0]), .ext_count_in_b_i(src_r[1]),
    .ext_count_in_c_i(src_r[2]), .ext_count_in_d_i(src_r[3]),
    .ch5_counter_wrap_i(src_r[4]), .count_tick_o(count_tick_o),
    .buffer_pair_a_en_o(buf_a_o), .buffer_pair_b_en_o(buf_b_o),
    .op_normal_o(nrm_o), .op_pwm1_o(pw1_o), .op_pwm2_o(pw2_o),
    .op_phase_o(phs_o), .op_phase_sel_o(psel_o),
    .gr_c_event_i(c_ev_r), .gr_d_event_i(d_ev_r),
    .gr_c_event_o(c_o), .gr_d_event_o(d_o));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chkv(16'(rdata_o), 16'(e));
  endtask

  task automatic tick_wait(input int k, output int n);
    n = 0;
    do
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    while (count_tick_o[k] !== 1'b1 && n < 5000);
    if (n >= 5000)
    begin
      err_total++;
      print_verdict();
    end
  endtask

  task automatic pulse(input int s);
    @(posedge mclk_i);
    src_r[s] <= 1'b1;
    if (s != 4)
      @(posedge mclk_i);
    @(posedge mclk_i);
    src_r[s] <= 1'b0;
    idle(5);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values();
    for (int a = 0; a < 16; a++)
      rd_chk(4'(a), (a < 6) ? 8'hc0 : 8'h00);
    chkv(16'(nrm_o), 16'h3f);
  endtask

  task automatic t_mode_rw();
    // counters stand still here, bit 3 written zero
    for (int c = 0; c < NUM_CH; c++)
      wr(4'(c), {4'h3, 1'b0, 3'(c)});
    for (int c = 0; c < NUM_CH; c++)
      rd_chk(4'(c), {2'h3, HAS_CD[c] ? 2'h3 : 2'h0, 1'b0,
        3'(c)});
    chkv(16'(buf_a_o), 16'(HAS_CD));
    chkv(16'(buf_b_o), 16'(HAS_CD));
    // back to normal mode so later tick scenarios are not gated
    for (int c = 0; c < NUM_CH; c++)
      wr(4'(c), 8'h00);
  endtask

  task automatic t_decode();
    for (int m = 0; m < 8; m++)
    begin
      wr(4'h1, 8'(m));
      #1;
      chkv({nrm_o[1], pw1_o[1], pw2_o[1], phs_o[1], psel_o[3:2]},
        {m == 0, m == 2, m == 3, m >= 4, 2'(m)});
    end
  endtask

  task automatic t_events();
    @(posedge mclk_i);
    c_ev_r <= 2'h3;
    d_ev_r <= 2'h3;
    for (int b = 0; b < 4; b++)
    begin
      wr(4'h0, {2'h0, 2'(b), 4'h0});
      wr(4'h3, {2'h0, 2'(b), 4'h0});
      #1;
      chkv(16'(c_o), b[0] ? 16'h0 : 16'h3);
      chkv(16'(d_o), b[1] ? 16'h0 : 16'h3);
    end
  endtask

  task automatic t_prescale();
    int n;
    for (int i = 0; i < 13; i++)
    begin
      wr(4'(8 + ps_ch[i]), 8'(ps_cs[i]));
      idle(2);
      tick_wait(ps_ch[i], n);
      tick_wait(ps_ch[i], n);
      chkv(16'(n), 16'(ps_dv[i]));
    end
  endtask

  task automatic t_ext();
    int c0;
    for (int i = 0; i < 10; i++)
    begin
      wr(4'(8 + ex_ch[i]), 8'(ex_cs[i]));
      idle(4);
      c0 = tick_cnt[ex_ch[i]];
      repeat (3) pulse(ex_sr[i]);
      pulse((ex_sr[i] + 1) % 5);
      chkv(16'(tick_cnt[ex_ch[i]] - c0), 16'h3);
    end
  endtask

  task automatic t_phase();
    int c0;
    for (int j = 0; j < 3; j++)
    begin
      wr(4'(8 + j + (j > 0)), 8'h0);
      wr(4'(2 + j + (j > 0)), 8'(4 + 2 * j - (j > 1)));
      idle(3);
      c0 = tick_cnt[j + (j > 0)];
      idle(20);
      chkv(16'(tick_cnt[j + (j > 0)] - c0), 16'h0);
      wr(4'(2 + j + (j > 0)), 8'h0);
      idle(3);
      c0 = tick_cnt[j + (j > 0)];
      idle(20);
      chkv(16'(tick_cnt[j + (j > 0)] - c0), 16'd20);
    end
  endtask

  task automatic t_ce_and_reset();
    wr(4'h0, 8'h00);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(4'h0, 8'h33);
    ce_i <= 1'b1;
    rd_chk(4'h0, 8'hc0);
    wr(4'h1, 8'h35);
    resetn_i <= 1'b0;
    idle(2);
    resetn_i <= 1'b1;
    idle(3);
    rd_chk(4'h1, 8'hc0);
  endtask

  initial
  begin
    idle(2);
    resetn_i <= 1'b1;
    idle(3);
    t_reset_values();
    t_mode_rw();
    t_decode();
    t_events();
    t_prescale();
    t_ext();
    t_phase();
    t_ce_and_reset();
    print_verdict();
  end
endmodule
